// file: include/sgl_pkg.sv
// Purpose: Shared constants and types of the serial gain word loader
// Assumes: Avalon-MM slave with byte addresses on a 4-bit address
// Notes:   Register offsets and layouts are used by core and bench alike
package sgl_pkg;

    localparam int          SGL_WORD_W      = 8;
    localparam int          SGL_CODE_W      = 6;
    localparam int          SGL_SYNC_N      = 3;
    localparam logic [5:0]  SGL_CODE_MIN    = 6'h01;
    localparam logic [5:0]  SGL_CODE_MAX    = 6'h3c;
    localparam logic [5:0]  SGL_GAIN_RST    = 6'h01;
    localparam logic [7:0]  SGL_WORD_RST    = 8'h00;

    // Register byte offsets
    localparam logic [3:0]  SGL_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  SGL_ADDR_STATUS = 4'h4;
    localparam logic [3:0]  SGL_ADDR_WORD   = 4'h8;
    localparam logic [3:0]  SGL_ADDR_LOADS  = 4'hc;

    // CTRL fields
    localparam int          SGL_CTRL_TXGATE = 0;
    localparam logic [31:0] SGL_CTRL_RST    = 32'h0000_0001;

    // STATUS fields
    localparam int          SGL_ST_CODE_LSB = 0;
    localparam int          SGL_ST_POWERED  = 8;
    localparam int          SGL_ST_TXPIN    = 9;
    localparam int          SGL_ST_FORWARD  = 10;
    localparam int          SGL_ST_LOADPIN  = 11;
    localparam int          SGL_ST_CLAMPED  = 16;
    localparam int          SGL_ST_LOADED   = 17;

    // WORD fields
    localparam int          SGL_WD_RAW_LSB  = 0;
    localparam int          SGL_WD_EFF_LSB  = 8;

    // Synchroniser lanes
    localparam int          SGL_SY_SLEEP    = 0;
    localparam int          SGL_SY_TX       = 1;
    localparam int          SGL_SY_LOAD     = 2;

    // Lane reset levels; load lane idles high so no false edge follows reset
    localparam logic [SGL_SYNC_N-1:0] SGL_SYNC_RST = 3'h4;

    localparam logic [15:0] SGL_LOADS_RST   = 16'h0000;
    localparam logic [15:0] SGL_LOADS_ONE   = 16'h0001;

    typedef enum logic {
        SGL_BUS_IDLE,
        SGL_BUS_ANSWER
    } sgl_bus_e;

endpackage : sgl_pkg

// file: include/sgl_link_if.sv
// Purpose: Carries the serial link between core and shifter
// Assumes: sclk is the controller's serial clock
// Notes:   word is stable while load_enable_n stays high
`timescale 1ns/1ps
interface sgl_link_if;
    import sgl_pkg::*;

    logic                  sclk;
    logic                  load_enable_n;
    logic                  serial_gain_in;
    logic [SGL_WORD_W-1:0] word;

    modport shifter (
        input  sclk,
        input  load_enable_n,
        input  serial_gain_in,
        output word
    );

    modport core (
        output sclk,
        output load_enable_n,
        output serial_gain_in,
        input  word
    );

endinterface : sgl_link_if

// file: core/sgl_shifter.sv
// Purpose: Master-slave serial shift register on the link clock
// Assumes: load_enable_n meets setup and hold against sclk
// Notes:   Clock may stop outside frames; nothing here needs it to run
`timescale 1ns/1ps
module sgl_shifter
    import sgl_pkg::*;
(
    input  wire logic rst,
    sgl_link_if.shifter link
);

    logic                  master_q;
    logic [SGL_WORD_W-1:0] slave_q;
    wire logic             shift_on;

    assign shift_on = ~link.load_enable_n;

    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            master_q <= 1'b0;
        end else if (shift_on) begin
            master_q <= link.serial_gain_in;
        end
    end

    // slave transfer on fall
    // Earlier bits move up, so the first bit ends as the MSB
    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            slave_q <= SGL_WORD_RST;
        end else if (shift_on) begin
            slave_q <= {slave_q[SGL_WORD_W-2:0], master_q};
        end
    end

    assign link.word = slave_q;

endmodule : sgl_shifter

// file: core/sgl_top.sv
// Purpose: Serial gain word loader with power controls and status
// Assumes: clk at 50 MHz; serial clock and pins come from the controller
// Notes:   Gain word crosses to clk only while the shift stage is frozen
//
// What this block does
// - Rising load enable copies shift register into the gain latch.
// - While load enable is high, no serial bits are accepted.
// - Falling load enable freezes latch, keeping the previous gain.
// - After load enable falls, the shift register accepts bits.
// - Serial clock rise captures the data bit into the master.
// - Serial clock fall moves the master bit into the slave.
// - Sleep low powers down with output high-Z; high powers up.
// - Transmit enable low disables forwarding; high enables it while the CTRL gate bit is set.
// - Only the six low bits of the word form the gain code.
// - Gain codes one to sixty are accepted, one unit per step.
// - Codes sixty-one to sixty-three apply code sixty, maximum gain.
`timescale 1ns/1ps
module sgl_top
    import sgl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  sclk,
    input  wire logic                  load_enable_n,
    input  wire logic                  serial_gain_in,
    input  wire logic                  transmit_on,
    input  wire logic                  sleep_n,
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic      [SGL_CODE_W-1:0] gain_code,
    output logic                       amp_powered,
    output logic                       output_hiz,
    output logic                       forward_enable
);

    // Gain code decode, shared by latch and WORD register readback
    function automatic logic [SGL_CODE_W-1:0] sgl_clamp(
        input logic [SGL_WORD_W-1:0] w
    );
        logic [SGL_CODE_W-1:0] c;
        c = w[SGL_CODE_W-1:0];
        if (c > SGL_CODE_MAX) begin
            sgl_clamp = SGL_CODE_MAX;
        end else if (c < SGL_CODE_MIN) begin
            sgl_clamp = SGL_CODE_MIN;
        end else begin
            sgl_clamp = c;
        end
    endfunction : sgl_clamp

    // Link side

    sgl_link_if link ();

    assign link.sclk           = sclk;
    assign link.load_enable_n  = load_enable_n;
    assign link.serial_gain_in = serial_gain_in;

    sgl_shifter u_shifter (
        .rst  (rst),
        .link (link)
    );

    // Pin synchronisers

    wire logic [SGL_SYNC_N-1:0] pin_raw;
    logic      [SGL_SYNC_N-1:0] sync1_q;
    logic      [SGL_SYNC_N-1:0] sync2_q;

    assign pin_raw[SGL_SY_SLEEP] = sleep_n;
    assign pin_raw[SGL_SY_TX]    = transmit_on;
    assign pin_raw[SGL_SY_LOAD]  = load_enable_n;

    // First stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < SGL_SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= SGL_SYNC_RST[gi];
                    sync2_q[gi] <= SGL_SYNC_RST[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire logic sleep_s;
    wire logic tx_s;
    wire logic load_s;

    assign sleep_s = sync2_q[SGL_SY_SLEEP];
    assign tx_s    = sync2_q[SGL_SY_TX];
    assign load_s  = sync2_q[SGL_SY_LOAD];

    // Load edge detection

    logic      load_prev_q;
    wire logic load_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_prev_q <= 1'b1;
        end else begin
            load_prev_q <= load_s;
        end
    end

    // rising load enable detected
    // Reset value high so a released reset never fakes a load
    assign load_rise = load_s & ~load_prev_q;

    // Gain latch

    logic [SGL_WORD_W-1:0] raw_word_q;
    logic [SGL_WORD_W-1:0] raw_word_d;
    logic [SGL_CODE_W-1:0] gain_q;
    logic [SGL_CODE_W-1:0] gain_d;
    wire  [SGL_CODE_W-1:0] load_code;
    wire  logic            load_clamps;

    // Shift stage is frozen while load enable is high, so the
    // word is quiet by the time the synchronised rise is seen
    // six low bits only
    assign load_code   = sgl_clamp(link.word);
    assign load_clamps = (load_code != link.word[SGL_CODE_W-1:0]);

    assign gain_d     = load_rise ? load_code : gain_q;
    assign raw_word_d = load_rise ? link.word : raw_word_q;

    // only the load edge writes it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_q     <= SGL_GAIN_RST;
            raw_word_q <= SGL_WORD_RST;
        end else begin
            gain_q     <= gain_d;
            raw_word_q <= raw_word_d;
        end
    end

    assign gain_code = gain_q;

    // Power and transmit

    logic      ctrl_txgate_q;
    logic      ctrl_txgate_d;
    logic      powered_q;
    logic      hiz_q;
    logic      forward_q;
    wire logic forward_d;

    // forwarding follows transmit enable
    // Software gate resets open; clearing it mutes the link
    assign forward_d = tx_s & ctrl_txgate_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powered_q <= 1'b0;
            hiz_q     <= 1'b1;
            forward_q <= 1'b0;
        end else begin
            powered_q <= sleep_s;
            hiz_q     <= ~sleep_s;
            forward_q <= forward_d;
        end
    end

    assign amp_powered    = powered_q;
    assign output_hiz     = hiz_q;
    assign forward_enable = forward_q;

    // Bus slave

    sgl_bus_e  bus_q;
    sgl_bus_e  bus_d;
    wire logic req;
    wire logic take;
    wire logic take_wr;

    assign req     = avs_read | avs_write;
    assign take    = (bus_q == SGL_BUS_ANSWER);
    assign take_wr = take & avs_write;

    // One wait cycle, then the held request is taken
    always_comb begin
        bus_d = bus_q;
        unique case (bus_q)
            SGL_BUS_IDLE: begin
                if (req) begin
                    bus_d = SGL_BUS_ANSWER;
                end
            end
            SGL_BUS_ANSWER: begin
                bus_d = SGL_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_q <= SGL_BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    assign avs_waitrequest = ~take;

    wire logic sel_ctrl;
    wire logic sel_status;
    wire logic sel_word;
    wire logic sel_loads;

    assign sel_ctrl   = (avs_address == SGL_ADDR_CTRL);
    assign sel_status = (avs_address == SGL_ADDR_STATUS);
    assign sel_word   = (avs_address == SGL_ADDR_WORD);
    assign sel_loads  = (avs_address == SGL_ADDR_LOADS);

    // Control register

    assign ctrl_txgate_d = (take_wr & sel_ctrl & avs_byteenable[0])
                         ? avs_writedata[SGL_CTRL_TXGATE]
                         : ctrl_txgate_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_txgate_q <= SGL_CTRL_RST[SGL_CTRL_TXGATE];
        end else begin
            ctrl_txgate_q <= ctrl_txgate_d;
        end
    end

    // Sticky flags, write one to clear

    logic      clamped_q;
    logic      loaded_q;
    wire logic clr_lane;
    wire logic clr_clamped;
    wire logic clr_loaded;

    assign clr_lane    = take_wr & sel_status & avs_byteenable[2];
    assign clr_clamped = clr_lane & avs_writedata[SGL_ST_CLAMPED];
    assign clr_loaded  = clr_lane & avs_writedata[SGL_ST_LOADED];

    // A load in the clearing cycle keeps its flag set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clamped_q <= 1'b0;
            loaded_q  <= 1'b0;
        end else begin
            clamped_q <= (load_rise & load_clamps) | (clamped_q & ~clr_clamped);
            loaded_q  <= load_rise | (loaded_q & ~clr_loaded);
        end
    end

    // Load counter wraps silently
    logic [15:0] loads_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loads_q <= SGL_LOADS_RST;
        end else if (load_rise) begin
            loads_q <= loads_q + SGL_LOADS_ONE;
        end
    end

    // Read mux

    logic [31:0] rd_status;
    logic [31:0] rd_word;
    logic [31:0] rd_mux;

    always_comb begin
        rd_status = 32'h0000_0000;
        rd_status[SGL_ST_CODE_LSB +: SGL_CODE_W] = gain_q;
        rd_status[SGL_ST_POWERED] = powered_q;
        rd_status[SGL_ST_TXPIN]   = tx_s;
        rd_status[SGL_ST_FORWARD] = forward_q;
        rd_status[SGL_ST_LOADPIN] = load_s;
        rd_status[SGL_ST_CLAMPED] = clamped_q;
        rd_status[SGL_ST_LOADED]  = loaded_q;
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[SGL_WD_RAW_LSB +: SGL_WORD_W] = raw_word_q;
        rd_word[SGL_WD_EFF_LSB +: SGL_CODE_W] = sgl_clamp(raw_word_q);
    end

    // Unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux[SGL_CTRL_TXGATE] = ctrl_txgate_q;
        end else if (sel_status) begin
            rd_mux = rd_status;
        end else if (sel_word) begin
            rd_mux = rd_word;
        end else if (sel_loads) begin
            rd_mux[15:0] = loads_q;
        end
    end

    // Captured in the wait cycle, stable when taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (!take && avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

endmodule : sgl_top

// file: verification/sgl_top_monitor.sv
// Purpose: Port-level checks of the gain loader
// Assumes: Load enable stays high a few clk cycles between frames
// Notes:   Serial pins are judged only by their clk-side effects
`timescale 1ns/1ps
module sgl_top_monitor
    import sgl_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  load_enable_n,
    input wire logic                  transmit_on,
    input wire logic                  sleep_n,
    input wire logic                  avs_read,
    input wire logic                  avs_waitrequest,
    input wire logic [SGL_CODE_W-1:0] gain_code,
    input wire logic                  amp_powered,
    input wire logic                  output_hiz,
    input wire logic                  forward_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_code_range: assert property (
        gain_code >= SGL_CODE_MIN && gain_code <= SGL_CODE_MAX)
        else $error("gain code outside one to sixty");
    a_latch_frozen: assert property (
        !load_enable_n |-> $stable(gain_code))
        else $error("gain moved while a frame was open");
    a_latch_on_load: assert property (
        $changed(gain_code) |-> load_enable_n)
        else $error("gain moved without a load");
    a_sleep_hiz: assert property (
        $fell(sleep_n) |-> ##[1:4] (output_hiz && !amp_powered))
        else $error("sleep did not power down");
    a_wake_up: assert property (
        $rose(sleep_n) |-> ##[1:4] (amp_powered && !output_hiz))
        else $error("wake did not power up");
    a_hiz_pair: assert property (
        output_hiz != amp_powered)
        else $error("powered and high-Z agree");
    a_fwd_off: assert property (
        $fell(transmit_on) ##1 !transmit_on [*4] |-> !forward_enable)
        else $error("forwarding kept with transmit low");
    a_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low two cycles");
    a_read_answer: assert property (
        $rose(avs_read) |-> ##[1:2] !avs_waitrequest)
        else $error("read not answered in time");
endmodule : sgl_top_monitor

bind sgl_top sgl_top_monitor i_sgl_top_monitor (
    .clk(clk), .rst(rst), .load_enable_n(load_enable_n),
    .transmit_on(transmit_on), .sleep_n(sleep_n), .avs_read(avs_read),
    .avs_waitrequest(avs_waitrequest), .gain_code(gain_code),
    .amp_powered(amp_powered), .output_hiz(output_hiz),
    .forward_enable(forward_enable)
);

// file: verification/sgl_ctrl_model.sv
// Purpose: Behavioural serial controller driving the gain pins
// Assumes: Caller waits for the task to end before the next frame
// Notes:   Serial clock rests low outside frames except in stray()
`timescale 1ns/1ps
module sgl_ctrl_model (
    output logic sclk,
    output logic load_enable_n,
    output logic serial_gain_in
);
    initial begin
        sclk = 1'b0;
        load_enable_n = 1'b1;
        serial_gain_in = 1'b1;
    end

    task automatic send_word(input logic [15:0] w, input int nb, input int half);
        #7 load_enable_n = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            serial_gain_in = w[i];
            #half sclk = 1'b1;
            #half sclk = 1'b0;
        end
        #half load_enable_n = 1'b1;
        // Released line shows no stale bit
        serial_gain_in = ~serial_gain_in;
    endtask : send_word

    // Clock pulses outside a frame, only on request
    task automatic stray(input int n);
        repeat (n) begin
            serial_gain_in = ~serial_gain_in;
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
    endtask : stray
endmodule : sgl_ctrl_model

// file: verification/sgl_top_tb.sv
// Purpose: Self-checking bench of the serial gain word loader
// Assumes: Avalon answers with one wait cycle; gain lands within 8 clk
// Notes:   Expected codes are worked out here, not read from the core
`timescale 1ns/1ps
module sgl_top_tb;
    import sgl_pkg::*;
    logic                  clk, rst, transmit_on, sleep_n, avs_read, avs_write;
    logic [3:0]            avs_address, avs_byteenable;
    logic [31:0]           avs_writedata, avs_readdata, rd;
    logic                  avs_waitrequest, amp_powered, output_hiz, forward_enable;
    logic                  sclk, load_enable_n, serial_gain_in;
    logic [SGL_CODE_W-1:0] gain_code;
    int                    num_errors, checks_done, loads;
    logic [7:0]            words [8] = '{8'h01, 8'h4b, 8'h3c, 8'h3d, 8'h3e, 8'h3f,
                                         8'h00, 8'hc5};

    sgl_top i_sgl_top (.clk(clk), .rst(rst), .sclk(sclk), .load_enable_n(load_enable_n),
        .serial_gain_in(serial_gain_in), .transmit_on(transmit_on), .sleep_n(sleep_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .gain_code(gain_code), .amp_powered(amp_powered), .output_hiz(output_hiz),
        .forward_enable(forward_enable));
    sgl_ctrl_model i_sgl_ctrl_model (.sclk(sclk), .load_enable_n(load_enable_n),
        .serial_gain_in(serial_gain_in));

    function automatic logic [5:0] exp_code(input logic [7:0] w);
        if (w[5:0] > SGL_CODE_MAX) return SGL_CODE_MAX;
        if (w[5:0] == 6'h00) return SGL_CODE_MIN;
        return w[5:0];
    endfunction : exp_code

    task automatic print_verdict;
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: output %h expected %h", $time, got, exp);
        end
    endtask : cmp_out

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_byteenable <= 4'hf;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus_rd

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus_wr

    task automatic load_chk(input logic [15:0] w, input int nb, input int half,
                            input logic [7:0] raw);
        i_sgl_ctrl_model.send_word(w, nb, half);
        repeat (8) @(posedge clk);
        loads++;
        cmp_out({2'h0, gain_code}, {2'h0, exp_code(raw)});
        bus_rd(SGL_ADDR_WORD, rd);
        cmp_reg({18'h0, rd[13:0]}, {18'h0, exp_code(raw), raw});
    endtask : load_chk

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Far longer than the whole sequence
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        transmit_on = 1'b1;
        sleep_n = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        cmp_out({2'h0, gain_code}, {2'h0, SGL_GAIN_RST});
        cmp_out({7'h0, forward_enable}, 8'h01);
        cmp_out({7'h0, amp_powered}, 8'h01);
        bus_rd(SGL_ADDR_CTRL, rd);
        cmp_reg(rd, SGL_CTRL_RST);
        bus_rd(4'h2, rd);
        cmp_reg(rd, 32'h0);
        foreach (words[i]) load_chk({8'h00, words[i]}, 8, 16, words[i]);
        i_sgl_ctrl_model.stray(6);
        load_chk(16'h0000, 0, 16, 8'hc5);
        load_chk(16'h0a17, 12, 16, 8'h17);
        load_chk(16'h0029, 8, 16, 8'h29);
        transmit_on <= 1'b0;
        repeat (5) @(posedge clk);
        cmp_out({7'h0, forward_enable}, 8'h00);
        sleep_n <= 1'b0;
        repeat (5) @(posedge clk);
        cmp_out({6'h0, output_hiz, amp_powered}, 8'h02);
        cmp_out({2'h0, gain_code}, 8'h29);
        load_chk(16'h0012, 8, 16, 8'h12);
        sleep_n <= 1'b1;
        transmit_on <= 1'b1;
        repeat (5) @(posedge clk);
        cmp_out({6'h0, output_hiz, forward_enable}, 8'h01);
        bus_wr(SGL_ADDR_CTRL, 32'h0, 4'h1);
        repeat (5) @(posedge clk);
        cmp_out({7'h0, forward_enable}, 8'h00);
        bus_wr(SGL_ADDR_CTRL, SGL_CTRL_RST, 4'h1);
        bus_rd(SGL_ADDR_LOADS, rd);
        cmp_reg(rd, 32'(loads));
        // Clamped and loaded flags still set from earlier frames
        bus_rd(SGL_ADDR_STATUS, rd);
        cmp_reg(rd, 32'h0003_0f12);
        bus_wr(SGL_ADDR_STATUS, 32'h0003_0000, 4'h4);
        bus_rd(SGL_ADDR_STATUS, rd);
        cmp_reg(rd, 32'h0000_0f12);
        print_verdict();
    end
endmodule : sgl_top_tb
